/* rtl/dsp_dual_port.sv */
module dsp_dual_port (
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    input  wire dsp_pkg::dsp_file_req_t FILE_REQ,
    output logic [7:0]                  FILE_RDATA,
    input  wire dsp_pkg::dsp_ctrl_load_t CTRL_LOAD,
    input  wire logic                   OPTION_LOAD,
    input  wire logic                   RMW_OP,
    input  wire logic                   RMW_SET,
    input  wire logic [2:0]             RMW_BIT,
    input  wire logic                   SLEEP_MODE,
    input  wire logic                   WAKE_RESET_CAUSE,
    input  wire logic                   OTHER_RESET_CAUSE,
    input  wire logic                   MASTER_CLEAR_MODE,
    input  wire logic [5:0]             ALT_FN_B,
    input  wire logic [5:0]             ALT_FN_C,
    input  wire logic [5:0]             PIN_B_I,
    output logic      [5:0]             PIN_B_O,
    output logic      [5:0]             PIN_B_OE_N,
    output logic      [5:0]             PULLUP_B_EN,
    input  wire logic [5:0]             PIN_C_I,
    output logic      [5:0]             PIN_C_O,
    output logic      [5:0]             PIN_C_OE_N,
    output logic                        TIMER_EXT_CLK,
    output logic                        WAKE_REQUEST
);
    logic [5:0] pin_b_sync;
    logic [5:0] pin_c_sync;
    logic [5:0] dir_b_ff;
    logic [5:0] dir_c_ff;
    logic [7:0] option_ff;
    logic [5:0] latch_b_ff;
    logic [5:0] latch_c_ff;
    logic [5:0] wake_ref_ff;
    logic       wake_flag_ff;
    logic       wake_req_ff;
    logic [7:0] rdata_ff;
    logic [5:0] read_b;
    logic [5:0] read_c;
    logic [5:0] grp_mask;
    logic [5:0] nxt_rmw;
    logic       hit_b;
    logic       hit_c;
    logic       wake_en;
    logic       pull_en;
    logic       timer_ovr;

    dsp_pin_sync u_sync_b (
        .clk      (CORE_CLK),
        .rst      (RST),
        .pin_in   (PIN_B_I),
        .pin_sync (pin_b_sync)
    );
    dsp_pin_sync u_sync_c (
        .clk      (CORE_CLK),
        .rst      (RST),
        .pin_in   (PIN_C_I),
        .pin_sync (pin_c_sync)
    );

    // ----------------------------------------------------------------
    // decode and read path
    // ----------------------------------------------------------------
    assign hit_b  = FILE_REQ.addr == dsp_pkg::ADDR_BANK_B;
    assign hit_c  = FILE_REQ.addr == dsp_pkg::ADDR_BANK_C;
    assign read_b = pin_b_sync & ~ALT_FN_B;
    assign read_c = pin_c_sync & ~ALT_FN_C;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rdata_ff <= '0;
        end else if (FILE_REQ.rd) begin
            if (hit_b) begin
                rdata_ff <= {2'h0, read_b};
            end else if (hit_c) begin
                rdata_ff <= {2'h0, read_c};
            end else if (FILE_REQ.addr == dsp_pkg::ADDR_STATUS) begin
                rdata_ff <= {wake_flag_ff, 7'h00};
            end else begin
                rdata_ff <= '0;
            end
        end
    end
    assign FILE_RDATA = rdata_ff;

    // ----------------------------------------------------------------
    // direction and option registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dir_b_ff <= dsp_pkg::DIR_RESET;
            dir_c_ff <= dsp_pkg::DIR_RESET;
        end else if (CTRL_LOAD.load) begin
            if (CTRL_LOAD.sel == dsp_pkg::DIR_SEL_B) begin
                dir_b_ff <= CTRL_LOAD.wdata[5:0];
            end else if (CTRL_LOAD.sel == dsp_pkg::DIR_SEL_C) begin
                dir_c_ff <= CTRL_LOAD.wdata[5:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            option_ff <= dsp_pkg::OPTION_RESET;
        end else if (OPTION_LOAD) begin
            option_ff <= CTRL_LOAD.wdata;
        end
    end

    // ----------------------------------------------------------------
    // output latches; bit ops fold live pins back in
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rmw = hit_c ? read_c : read_b;
        if (RMW_BIT < 3'h6) begin
            nxt_rmw[RMW_BIT] = RMW_SET;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            latch_b_ff <= '0;
            latch_c_ff <= '0;
        end else if (FILE_REQ.wr) begin
            if (hit_b) begin
                latch_b_ff <= RMW_OP ? nxt_rmw : FILE_REQ.wdata[5:0];
            end
            if (hit_c) begin
                latch_c_ff <= RMW_OP ? nxt_rmw : FILE_REQ.wdata[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    assign timer_ovr = option_ff[dsp_pkg::OPT_TMR_SRC];
    assign PIN_B_O   = latch_b_ff;
    assign PIN_C_O   = latch_c_ff;

    genvar gi;
    generate
        for (gi = 0; gi < dsp_pkg::PORT_W; gi++) begin : g_drv
            if (gi == dsp_pkg::INPUT_ONLY_BIT) begin : g_in_only
                assign PIN_B_OE_N[gi] = 1'b1;
            end else begin : g_b
                assign PIN_B_OE_N[gi] = dir_b_ff[gi];
            end
            if (gi == dsp_pkg::TIMER_PIN_BIT) begin : g_tmr
                assign PIN_C_OE_N[gi] = dir_c_ff[gi] | timer_ovr;
            end else begin : g_c
                assign PIN_C_OE_N[gi] = dir_c_ff[gi];
            end
        end
    endgenerate
    assign TIMER_EXT_CLK = timer_ovr & pin_c_sync[dsp_pkg::TIMER_PIN_BIT];

    // ----------------------------------------------------------------
    // group pull-ups and wake on change
    // ----------------------------------------------------------------
    assign wake_en = ~option_ff[dsp_pkg::OPT_WAKE_N];
    assign pull_en = ~option_ff[dsp_pkg::OPT_PULLUP_N];
    // output pins and a master-clear pin drop out of the group
    assign grp_mask = dsp_pkg::WAKE_GROUP_MASK & dir_b_ff
                    & ~(MASTER_CLEAR_MODE ? 6'(1 << dsp_pkg::INPUT_ONLY_BIT)
                                          : 6'h00);
    assign PULLUP_B_EN = pull_en ? grp_mask : 6'h00;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wake_ref_ff <= '0;
        end else if (FILE_REQ.rd && hit_b) begin
            wake_ref_ff <= pin_b_sync;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wake_req_ff <= 1'b0;
        end else begin
            wake_req_ff <= SLEEP_MODE && wake_en
                        && |((pin_b_sync ^ wake_ref_ff) & grp_mask);
        end
    end
    assign WAKE_REQUEST = wake_req_ff;

    // reset cause is cleared by core reset; a wake cause sets it, any other cause clears it unless a wake cause comes in the same cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wake_flag_ff <= 1'b0;
        end else if (WAKE_RESET_CAUSE) begin
            wake_flag_ff <= 1'b1;
        end else if (OTHER_RESET_CAUSE) begin
            wake_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_read_upper_zero: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.rd && (hit_b || hit_c) |=> FILE_RDATA[7:6] == 2'h0)
        else $error("upper port bits not zero");
    a_read_pins_b: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.rd && hit_b |=> FILE_RDATA[5:0] == $past(read_b))
        else $error("port b read mismatch");
    a_input_only: assert property (@(posedge CORE_CLK) disable iff (RST)
        PIN_B_OE_N[dsp_pkg::INPUT_ONLY_BIT])
        else $error("input-only pin driven");
    a_dir_load_b: assert property (@(posedge CORE_CLK) disable iff (RST)
        CTRL_LOAD.load && CTRL_LOAD.sel == dsp_pkg::DIR_SEL_B
        |=> PIN_B_OE_N[2:0] == $past(CTRL_LOAD.wdata[2:0]))
        else $error("direction load failed");
    a_dir_hold_c: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CTRL_LOAD.load |=> PIN_C_OE_N[4:0] == $past(PIN_C_OE_N[4:0]))
        else $error("direction changed without load");
    a_latch_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        !FILE_REQ.wr |=> $stable(PIN_B_O) && $stable(PIN_C_O))
        else $error("latch changed without write");
    a_output_no_pull: assert property (@(posedge CORE_CLK) disable iff (RST)
        (PULLUP_B_EN & ~PIN_B_OE_N) == 6'h00)
        else $error("pull-up on output pin");
    a_clear_pin_pull: assert property (@(posedge CORE_CLK) disable iff (RST)
        MASTER_CLEAR_MODE |-> !PULLUP_B_EN[dsp_pkg::INPUT_ONLY_BIT])
        else $error("pull-up on master clear");
    a_timer_float: assert property (@(posedge CORE_CLK) disable iff (RST)
        option_ff[dsp_pkg::OPT_TMR_SRC] |-> PIN_C_OE_N[dsp_pkg::TIMER_PIN_BIT])
        else $error("timer pin driven");
    // the cause pulse may still stand while the status read is taken
    a_wake_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        WAKE_RESET_CAUSE ##1 (FILE_REQ.rd && FILE_REQ.addr == dsp_pkg::ADDR_STATUS
        && !OTHER_RESET_CAUSE) |=> FILE_RDATA[dsp_pkg::STATUS_WAKE_BIT])
        else $error("wake flag lost");
    a_wake_gated: assert property (@(posedge CORE_CLK) disable iff (RST)
        $past(option_ff[dsp_pkg::OPT_WAKE_N]) |-> !WAKE_REQUEST)
        else $error("wake while disabled");

    a_read_pins_c: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.rd && hit_c |=> FILE_RDATA[5:0] == $past(pin_c_sync & ~ALT_FN_C))
        else $error("port c read mismatch");
    a_pull_group: assert property (@(posedge CORE_CLK) disable iff (RST)
        (PULLUP_B_EN & ~dsp_pkg::WAKE_GROUP_MASK) == 6'h00)
        else $error("pull-up outside group");
    a_pull_gated: assert property (@(posedge CORE_CLK) disable iff (RST)
        option_ff[dsp_pkg::OPT_PULLUP_N] |-> PULLUP_B_EN == 6'h00)
        else $error("pull-up while disabled");
    a_wake_sleep: assert property (@(posedge CORE_CLK) disable iff (RST)
        !$past(SLEEP_MODE) |-> !WAKE_REQUEST)
        else $error("wake while awake");
    a_status_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        OTHER_RESET_CAUSE && !WAKE_RESET_CAUSE |=> !wake_flag_ff)
        else $error("wake flag kept");
    a_latch_write_b: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.wr && hit_b && !RMW_OP |=> PIN_B_O == $past(FILE_REQ.wdata[5:0]))
        else $error("port b latch write failed");
    a_latch_write_c: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.wr && hit_c && !RMW_OP |=> PIN_C_O == $past(FILE_REQ.wdata[5:0]))
        else $error("port c latch write failed");
    a_rmw_bit_b: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.wr && hit_b && RMW_OP && RMW_BIT < dsp_pkg::PORT_W
        |=> PIN_B_O[$past(RMW_BIT)] == $past(RMW_SET))
        else $error("bit op on port b failed");
    a_rmw_bit_c: assert property (@(posedge CORE_CLK) disable iff (RST)
        FILE_REQ.wr && hit_c && RMW_OP && RMW_BIT < dsp_pkg::PORT_W
        |=> PIN_C_O[$past(RMW_BIT)] == $past(RMW_SET))
        else $error("bit op on port c failed");
    a_dir_load_c: assert property (@(posedge CORE_CLK) disable iff (RST)
        CTRL_LOAD.load && CTRL_LOAD.sel == dsp_pkg::DIR_SEL_C
        |=> PIN_C_OE_N[4:0] == $past(CTRL_LOAD.wdata[4:0]))
        else $error("port c direction load failed");
    a_timer_clk_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        !option_ff[dsp_pkg::OPT_TMR_SRC] |-> !TIMER_EXT_CLK)
        else $error("timer clock without source select");

    // ----------------------------------------------------------------
    // scenario coverage
    // ----------------------------------------------------------------
    c_rmw_b:   cover property (@(posedge CORE_CLK) FILE_REQ.wr && hit_b && RMW_OP);
    c_flag:    cover property (@(posedge CORE_CLK) wake_flag_ff);
    c_wake:    cover property (@(posedge CORE_CLK) WAKE_REQUEST);
    c_drive_c: cover property (@(posedge CORE_CLK) PIN_C_OE_N != 6'h3F);
endmodule

/* rtl/dsp_pin_sync.sv */
module dsp_pin_sync (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [dsp_pkg::PORT_W-1:0] pin_in,
    output logic      [dsp_pkg::PORT_W-1:0] pin_sync
);
    logic [dsp_pkg::PORT_W-1:0] meta_ff;

    // first stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff  <= '0;
            pin_sync <= '0;
        end else begin
            meta_ff  <= pin_in;
            pin_sync <= meta_ff;
        end
    end
endmodule

/* rtl/dsp_pkg.sv */
package dsp_pkg;
    localparam int PORT_W = 6;
    localparam int REG_W  = 8;

    // register file addresses
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_BANK_B = 7'h06;
    localparam logic [6:0] ADDR_BANK_C = 7'h07;

    // direction load selectors
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;

    localparam logic [5:0] DIR_RESET    = 6'h3F;
    localparam logic [7:0] OPTION_RESET = 8'hFF;

    // option fields
    localparam int OPT_WAKE_N   = 7;
    localparam int OPT_PULLUP_N = 6;
    localparam int OPT_TMR_SRC  = 5;

    // status bit and pin positions
    localparam int STATUS_WAKE_BIT = 7;
    localparam int INPUT_ONLY_BIT  = 3;
    localparam int TIMER_PIN_BIT   = 5;
    localparam logic [5:0] WAKE_GROUP_MASK = 6'h1B;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dsp_file_req_t;

    typedef struct packed {
        logic       load;
        logic [2:0] sel;
        logic [7:0] wdata;
    } dsp_ctrl_load_t;
endpackage

/* testbench/dsp_pin_model.sv */
// ----------------------------------------
// board side of both six-bit banks
// ----------------------------------------
module dsp_pin_model (
    input  wire logic       clk,
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] oe_n,
    input  wire logic [5:0] pullup_en,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // floating pins toggle every clock, so a stale level never holds as a steady match
    logic [5:0] float_ff = 6'h15;
    always_ff @(posedge clk) begin
        float_ff <= ~float_ff;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (ext_en[i])
                pin_i[i] = ext_val[i]; // board overpowers driver
            else if (!oe_n[i])
                pin_i[i] = pin_o[i];
            else if (pullup_en[i])
                pin_i[i] = 1'b1;
            else
                pin_i[i] = float_ff[i];
        end
    end
endmodule

/* testbench/dual_six_bit_io_port_tb.sv */
module dual_six_bit_io_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 0, RST = 1, OPTION_LOAD = 0, RMW_OP = 0, RMW_SET = 0, SLEEP_MODE = 0;
    logic WAKE_RESET_CAUSE = 0, OTHER_RESET_CAUSE = 0, MASTER_CLEAR_MODE = 0;
    logic TIMER_EXT_CLK, WAKE_REQUEST;
    logic [2:0] RMW_BIT = 0;
    logic [5:0] ALT_FN_B = 0, ALT_FN_C = 0, PIN_B_I, PIN_B_O, PIN_B_OE_N, PULLUP_B_EN;
    logic [5:0] PIN_C_I, PIN_C_O, PIN_C_OE_N, eb = 0, vb = 0, ec = 0, vc = 0;
    logic [7:0] FILE_RDATA, rd_v;
    dsp_pkg::dsp_file_req_t  FILE_REQ  = '0;
    dsp_pkg::dsp_ctrl_load_t CTRL_LOAD = '0;
    int mismatches = 0;
    int check_count = 0;

    always #50 CORE_CLK = ~CORE_CLK;

    dsp_dual_port dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .FILE_REQ(FILE_REQ),
        .FILE_RDATA(FILE_RDATA), .CTRL_LOAD(CTRL_LOAD), .OPTION_LOAD(OPTION_LOAD),
        .RMW_OP(RMW_OP), .RMW_SET(RMW_SET), .RMW_BIT(RMW_BIT), .SLEEP_MODE(SLEEP_MODE),
        .WAKE_RESET_CAUSE(WAKE_RESET_CAUSE), .OTHER_RESET_CAUSE(OTHER_RESET_CAUSE),
        .MASTER_CLEAR_MODE(MASTER_CLEAR_MODE), .ALT_FN_B(ALT_FN_B), .ALT_FN_C(ALT_FN_C),
        .PIN_B_I(PIN_B_I),
        .PIN_B_O(PIN_B_O), .PIN_B_OE_N(PIN_B_OE_N), .PULLUP_B_EN(PULLUP_B_EN),
        .PIN_C_I(PIN_C_I), .PIN_C_O(PIN_C_O), .PIN_C_OE_N(PIN_C_OE_N),
        .TIMER_EXT_CLK(TIMER_EXT_CLK), .WAKE_REQUEST(WAKE_REQUEST));
    dsp_pin_model bank_b_u (.clk(CORE_CLK), .pin_o(PIN_B_O), .oe_n(PIN_B_OE_N),
        .pullup_en(PULLUP_B_EN), .ext_en(eb), .ext_val(vb), .pin_i(PIN_B_I));
    dsp_pin_model bank_c_u (.clk(CORE_CLK), .pin_o(PIN_C_O), .oe_n(PIN_C_OE_N),
        .pullup_en(6'h00), .ext_en(ec), .ext_val(vc), .pin_i(PIN_C_I));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge CORE_CLK);
        FILE_REQ <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge CORE_CLK);
        FILE_REQ <= '0;
        #1;
        rd_v = FILE_RDATA;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic op,
                      input logic s, input logic [2:0] b);
        @(posedge CORE_CLK);
        FILE_REQ <= '{1'b0, 1'b1, a, d};
        RMW_OP <= op;
        RMW_SET <= s;
        RMW_BIT <= b;
        @(posedge CORE_CLK);
        FILE_REQ <= '0;
        RMW_OP <= 1'b0;
        #1;
    endtask
    task automatic ld(input logic [2:0] s, input logic [7:0] d, input logic opt);
        @(posedge CORE_CLK);
        CTRL_LOAD <= '{!opt, s, d};
        OPTION_LOAD <= opt;
        @(posedge CORE_CLK);
        CTRL_LOAD <= '0;
        OPTION_LOAD <= 1'b0;
        #1;
    endtask
    // pins pass a two-flop synchroniser, so settle before sampling
    task automatic pins(input logic [5:0] be, bv, ce, cv);
        @(posedge CORE_CLK);
        {eb, vb, ec, vc} <= {be, bv, ce, cv};
        repeat (4) @(posedge CORE_CLK);
        #1;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        #1;
        cmp(8'(PIN_B_OE_N), 8'h3F);
        cmp(8'(PIN_C_OE_N), 8'h3F);
        cmp(8'(PULLUP_B_EN), 8'h00);
        pins(6'h3F, 6'h25, 6'h3F, 6'h1A);
        rd(dsp_pkg::ADDR_BANK_B);
        cmp(rd_v, 8'h25);
        rd(dsp_pkg::ADDR_BANK_C);
        cmp(rd_v, 8'h1A);
        ALT_FN_B <= 6'h04;
        rd(dsp_pkg::ADDR_BANK_B);
        cmp(rd_v, 8'h21);
        ALT_FN_B <= 6'h00;
        rd(7'h10);
        cmp(rd_v, 8'h00);
        ld(dsp_pkg::DIR_SEL_B, 8'h00, 1'b0);
        cmp(8'(PIN_B_OE_N), 8'h08);
        wr(dsp_pkg::ADDR_BANK_B, 8'h2A, 1'b0, 1'b0, 3'h0);
        cmp(8'(PIN_B_O), 8'h2A);
        rd(dsp_pkg::ADDR_BANK_B);
        cmp(rd_v, 8'h25);
        pins(6'h08, 6'h08, 6'h3F, 6'h3A);
        rd(dsp_pkg::ADDR_BANK_B);
        cmp(rd_v, 8'h2A);
        wr(dsp_pkg::ADDR_BANK_C, 8'h15, 1'b0, 1'b0, 3'h0);
        cmp(8'(PIN_B_O), 8'h2A);
        ld(dsp_pkg::DIR_SEL_B, 8'h08, 1'b0);
        ld(3'h0, 8'h20, 1'b1);
        cmp(8'(PULLUP_B_EN), 8'h08);
        ld(dsp_pkg::DIR_SEL_C, 8'h00, 1'b0);
        cmp(8'(PIN_C_OE_N), 8'h20);
        cmp(8'(TIMER_EXT_CLK), 8'h01);
        ld(dsp_pkg::DIR_SEL_B, 8'h3F, 1'b0);
        cmp(8'(PULLUP_B_EN), 8'h1B);
        MASTER_CLEAR_MODE <= 1'b1;
        @(posedge CORE_CLK);
        #1;
        cmp(8'(PULLUP_B_EN), 8'h13);
        MASTER_CLEAR_MODE <= 1'b0;
        pins(6'h3F, 6'h15, 6'h3F, 6'h3A);
        wr(dsp_pkg::ADDR_BANK_B, 8'h00, 1'b1, 1'b1, 3'h1);
        cmp(8'(PIN_B_O), 8'h17);
        wr(dsp_pkg::ADDR_BANK_B, 8'h00, 1'b1, 1'b0, 3'h2);
        cmp(8'(PIN_B_O), 8'h11);
        rd(dsp_pkg::ADDR_BANK_B);
        SLEEP_MODE <= 1'b1;
        pins(6'h3F, 6'h14, 6'h3F, 6'h3A);
        for (int i = 0; i < 10 && WAKE_REQUEST !== 1'b1; i++)
            @(posedge CORE_CLK);
        #1;
        cmp(8'(WAKE_REQUEST), 8'h01);
        SLEEP_MODE <= 1'b0;
        WAKE_RESET_CAUSE <= 1'b1;
        rd(dsp_pkg::ADDR_STATUS);
        WAKE_RESET_CAUSE <= 1'b0;
        rd(dsp_pkg::ADDR_STATUS);
        cmp(rd_v, 8'h80);
        OTHER_RESET_CAUSE <= 1'b1;
        rd(dsp_pkg::ADDR_STATUS);
        OTHER_RESET_CAUSE <= 1'b0;
        rd(dsp_pkg::ADDR_STATUS);
        cmp(rd_v, 8'h00);
        ld(3'h0, 8'hFF, 1'b1);
        cmp(8'(PULLUP_B_EN), 8'h00);
        end_sim();
    end

    // whole run is about 70 cycles; 2000 cycles, some thirty times that, means a hang
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule
